// file: rtl/opq_pkg.sv
// Purpose: shared constants for the operand queue with deferred release
// Assumes: one 40 MHz clock, AXI4-Lite register access, 32-bit data
// Notes: STATUS_OFFSET, OFFRAM_BASE and OFFRAM_END are byte addresses on the register bus
package opq_pkg;
    localparam int          DEPTH          = 16;
    localparam int          LANES          = 8;
    localparam int          HALF_W         = 16;
    localparam int          CTL_W          = 4;
    localparam int          OFF_ENTRIES    = 16;
    localparam int          CLK_PERIOD_NS  = 25;
    localparam logic [11:0] STATUS_OFFSET  = 12'h000;
    localparam logic [11:0] OFFRAM_BASE    = 12'h040;
    localparam logic [11:0] OFFRAM_END     = 12'h0c0;
    localparam int          ST_USED_POS    = 0;
    localparam int          ST_REL_POS     = 8;
    localparam int          ST_RD_POS      = 16;
    localparam int          ST_WR_POS      = 24;
    localparam int          ST_FULL_POS    = 31;
    localparam logic [31:0] OFFSET_RESET   = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage : opq_pkg

// file: rtl/operand_queue_with_release.sv
// Purpose: operand queue between fetch stages and the execution unit
// Assumes: load strobes and increment come from logic on ref_clk_in
// Notes: offset RAM is filled over AXI4-Lite; status is read-only
//
// Local design decisions: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/10ps
module operand_queue_with_release #(
    parameter int DEPTH  = opq_pkg::DEPTH,
    parameter int LANES  = opq_pkg::LANES,
    parameter int CTL_W  = opq_pkg::CTL_W,
    parameter int OFF_N  = opq_pkg::OFF_ENTRIES
) (
    input  wire logic                    ref_clk_in,
    input  wire logic                    rst_in,
    input  wire logic                    load_first_operand_in,
    input  wire logic                    load_second_operand_in,
    input  wire logic                    load_shared_control_bits_in,
    input  wire logic                    release_everything_in,
    input  wire logic [4:0]              increment_in,
    input  wire logic [3:0]              offset_select_in,
    input  wire logic                    quad_select_in,
    input  wire logic [63:0]             first_operand_data_in,
    input  wire logic [63:0]             second_operand_data_in,
    input  wire logic [127:0]            quad_data_in,
    input  wire logic [CTL_W-1:0]        first_control_in,
    input  wire logic [CTL_W-1:0]        second_control_in,
    input  wire logic [CTL_W-1:0]        shared_control_in,
    output logic                         load_stall_out,
    output logic                         operands_ready_out,
    input  wire logic                    operands_taken_in,
    output logic [127:0]                 output_operand_out,
    output logic [CTL_W-1:0]             first_control_out,
    output logic [CTL_W-1:0]             second_control_out,
    output logic [CTL_W-1:0]             shared_control_out,
    input  wire logic [11:0]             s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [11:0]             s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready
);
    localparam int AW = $clog2(DEPTH);
    localparam int UW = $clog2(DEPTH + 1);
    localparam int HW = opq_pkg::HALF_W;
    localparam int OW = $clog2(OFF_N);

    function automatic logic [AW-1:0] add_off(input logic [AW-1:0] base,
                                              input logic [AW-1:0] off);
        add_off = AW'(base + off);
    endfunction : add_off

    function automatic logic in_offram(input logic [11:0] a);
        in_offram = (a >= opq_pkg::OFFRAM_BASE) && (a < opq_pkg::OFFRAM_END);
    endfunction : in_offram

    // queue state
    logic [UW-1:0]      used_q;
    logic [UW-1:0]      released_q;
    logic [AW-1:0]      rd_addr_q;
    logic [AW-1:0]      wr_addr_q;
    logic               full_q;
    logic [HW-1:0]      data_mem [LANES][DEPTH];
    logic [CTL_W-1:0]   ctl1_mem [DEPTH];
    logic [CTL_W-1:0]   ctl2_mem [DEPTH];
    logic [CTL_W-1:0]   ctlb_mem [DEPTH];
    logic [31:0]        lane_off_q [OFF_N];
    logic [AW-1:0]      ctl_off_q  [OFF_N];
    logic [127:0]       out_data_q;
    logic [CTL_W-1:0]   out_ctl1_q;
    logic [CTL_W-1:0]   out_ctl2_q;
    logic [CTL_W-1:0]   out_ctlb_q;

    logic               load_req;
    logic               overflow;
    logic               load_go;
    logic               xfer;
    logic [UW-1:0]      used_d;
    logic [UW-1:0]      released_d;
    logic [AW-1:0]      ctl_addr;
    logic [31:0]        sel_lane_off;

    assign load_req = load_first_operand_in | load_second_operand_in
                    | load_shared_control_bits_in;
    assign overflow = ({1'b0, used_q} + {1'b0, increment_in})
                      > (UW + 1)'(DEPTH);
    assign load_go        = load_req && !overflow;
    assign load_stall_out = load_req && overflow;
    assign sel_lane_off   = lane_off_q[offset_select_in[OW-1:0]];
    assign ctl_addr = add_off(wr_addr_q,
                              ctl_off_q[offset_select_in[OW-1:0]]);

    // only released entries move; a take frees the slot the same cycle
    assign xfer = (released_q != '0)
                  && (!full_q || operands_taken_in);

    always_comb begin
        used_d = used_q;
        if (load_go) begin
            used_d = UW'(used_d + increment_in);
        end
        if (xfer) begin
            used_d = UW'(used_d - 1'b1);
        end
        released_d = xfer ? UW'(released_q - 1'b1) : released_q;
        if (release_everything_in && !load_stall_out) begin
            released_d = used_d;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            used_q     <= '0;
            released_q <= '0;
            rd_addr_q  <= '0;
            wr_addr_q  <= '0;
        end else begin
            used_q     <= used_d;
            released_q <= released_d;
            if (xfer) begin
                rd_addr_q <= AW'(rd_addr_q + 1'b1);
            end
            if (load_go) begin
                wr_addr_q <= AW'(wr_addr_q + increment_in);
            end
        end
    end

    // per-lane write: lanes 0-3 first operand, 4-7 second, or a quadword
    for (genvar i = 0; i < LANES; i++) begin : g_lane
        logic [AW-1:0] lane_addr;
        logic [HW-1:0] lane_data;
        logic          lane_we;
        assign lane_addr = add_off(wr_addr_q,
                                   sel_lane_off[i*AW +: AW]);
        assign lane_data = quad_select_in ? quad_data_in[i*HW +: HW]
                         : (i < LANES/2)
                         ? first_operand_data_in[(i%4)*HW +: HW]
                         : second_operand_data_in[(i%4)*HW +: HW];
        assign lane_we = load_go && (quad_select_in
                         ? (load_first_operand_in | load_second_operand_in)
                         : (i < LANES/2) ? load_first_operand_in
                         : load_second_operand_in);
        always_ff @(posedge ref_clk_in) begin
            if (lane_we) begin
                data_mem[i][lane_addr] <= lane_data;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (load_go && load_first_operand_in) begin
            ctl1_mem[ctl_addr] <= first_control_in;
        end
        if (load_go && load_second_operand_in) begin
            ctl2_mem[ctl_addr] <= second_control_in;
        end
        if (load_go && load_shared_control_bits_in) begin
            ctlb_mem[ctl_addr] <= shared_control_in;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            full_q <= 1'b0;
        end else if (xfer) begin
            full_q <= 1'b1;
        end else if (operands_taken_in) begin
            full_q <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            out_data_q <= '0;
            out_ctl1_q <= '0;
            out_ctl2_q <= '0;
            out_ctlb_q <= '0;
        end else if (xfer) begin
            for (int k = 0; k < LANES; k++) begin
                out_data_q[k*HW +: HW] <= data_mem[k][rd_addr_q];
            end
            out_ctl1_q <= ctl1_mem[rd_addr_q];
            out_ctl2_q <= ctl2_mem[rd_addr_q];
            out_ctlb_q <= ctlb_mem[rd_addr_q];
        end
    end

    assign operands_ready_out = full_q;
    assign output_operand_out = out_data_q;
    assign first_control_out  = out_ctl1_q;
    assign second_control_out = out_ctl2_q;
    assign shared_control_out = out_ctlb_q;

    // register bus: write path
    logic               aw_held_q;
    logic               w_held_q;
    logic [11:0]        awaddr_q;
    logic [31:0]        wdata_q;
    logic [3:0]         wstrb_q;
    logic               bvalid_q;
    logic [1:0]         bresp_q;
    logic               do_wr;
    logic [31:0]        strb_mask;
    logic [OW-1:0]      wr_entry;

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign do_wr         = aw_held_q && w_held_q && !bvalid_q;
    assign wr_entry      = awaddr_q[OW+2:3];
    assign strb_mask     = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                            {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            aw_held_q <= 1'b0;
            w_held_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            bvalid_q  <= 1'b0;
            bresp_q   <= opq_pkg::RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (do_wr) begin
                aw_held_q <= 1'b0;
                w_held_q  <= 1'b0;
                bvalid_q  <= 1'b1;
                bresp_q   <= (in_offram(awaddr_q)
                             || awaddr_q == opq_pkg::STATUS_OFFSET)
                             ? opq_pkg::RESP_OKAY : opq_pkg::RESP_SLVERR;
            end else if (bvalid_q && s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            for (int e = 0; e < OFF_N; e++) begin
                lane_off_q[e] <= opq_pkg::OFFSET_RESET;
                ctl_off_q[e]  <= '0;
            end
        end else if (do_wr && in_offram(awaddr_q)) begin
            if (!awaddr_q[2]) begin
                lane_off_q[wr_entry] <= (lane_off_q[wr_entry] & ~strb_mask)
                                      | (wdata_q & strb_mask);
            end else if (wstrb_q[0]) begin
                ctl_off_q[wr_entry] <= wdata_q[AW-1:0];
            end
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // register bus: read path
    logic               rvalid_q;
    logic [31:0]        rdata_q;
    logic [1:0]         rresp_q;
    logic [31:0]        status_word;
    logic [OW-1:0]      rd_entry;

    assign s_axi_arready = !rvalid_q;
    assign rd_entry      = s_axi_araddr[OW+2:3];

    always_comb begin
        status_word = '0;
        status_word[opq_pkg::ST_USED_POS +: UW] = used_q;
        status_word[opq_pkg::ST_REL_POS  +: UW] = released_q;
        status_word[opq_pkg::ST_RD_POS   +: AW] = rd_addr_q;
        status_word[opq_pkg::ST_WR_POS   +: AW] = wr_addr_q;
        status_word[opq_pkg::ST_FULL_POS]       = full_q;
    end

    always_ff @(posedge ref_clk_in or posedge rst_in) begin
        if (rst_in) begin
            rvalid_q <= 1'b0;
            rdata_q  <= '0;
            rresp_q  <= opq_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rresp_q  <= opq_pkg::RESP_OKAY;
            if (s_axi_araddr == opq_pkg::STATUS_OFFSET) begin
                rdata_q <= status_word;
            end else if (in_offram(s_axi_araddr)) begin
                rdata_q <= s_axi_araddr[2] ? 32'(ctl_off_q[rd_entry])
                                           : lane_off_q[rd_entry];
            end else begin
                rdata_q <= '0;
                rresp_q <= opq_pkg::RESP_SLVERR;
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;

    // checks
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (rst_in);

    sequence take_s;
        full_q && operands_taken_in;
    endsequence
    sequence refill_s;
        take_s and (released_q != '0);
    endsequence

    occupancy_bound_a: assert property (used_q <= UW'(DEPTH))
        else $error("occupancy beyond depth");
    stall_hold_a: assert property (load_stall_out |=>
        wr_addr_q == $past(wr_addr_q))
        else $error("write address moved during stall");
    wr_advance_a: assert property (load_go |=>
        wr_addr_q == AW'($past(wr_addr_q) + $past(increment_in)))
        else $error("write address not advanced by increment");
    release_bound_a: assert property (released_q <= used_q)
        else $error("released count above occupancy");
    release_all_a: assert property (release_everything_in
        && !load_stall_out |=> released_q == used_q)
        else $error("release did not cover all entries");
    no_bubble_a: assert property (refill_s |=> operands_ready_out)
        else $error("bubble after take and refill");
    take_empty_a: assert property (take_s and (released_q == '0)
        |=> !operands_ready_out)
        else $error("ready stayed after take with nothing released");
    fill_ready_a: assert property (!full_q && released_q != '0
        |=> operands_ready_out ##0 rd_addr_q == AW'($past(rd_addr_q) + 1'b1))
        else $error("ready entry not moved to output register");
    hold_unreleased_a: assert property (released_q == '0
        && !full_q |=> !operands_ready_out)
        else $error("unreleased entry delivered");
endmodule : operand_queue_with_release

// file: tb/exec_unit_model.sv
// Purpose: behavioural execution unit that consumes queued operands
// Assumes: bench raises hold_in to stall the unit between edges
// Notes: every accepted operand is logged in arrival order
`timescale 1ns/10ps
module exec_unit_model (
    input  wire logic         ref_clk_in,
    input  wire logic         hold_in,
    input  wire logic         ready_in,
    input  wire logic [127:0] data_in,
    input  wire logic [11:0]  ctl_in,
    output logic              taken_out
);
    logic [127:0] seen   [0:31];
    logic [11:0]  seen_c [0:31];
    int           got = 0;

    // accept only a presented operand, and only while not stalling
    assign taken_out = ready_in & ~hold_in;

    always @(posedge ref_clk_in) begin
        if (ready_in === 1'b1 && taken_out === 1'b1) begin
            seen[got % 32]   <= data_in;
            seen_c[got % 32] <= ctl_in;
            got              <= got + 1;
        end
    end
endmodule : exec_unit_model

// file: tb/tb_operand_queue_with_release.sv
// Purpose: self-checking bench for the operand queue
// Assumes: the execution unit model stalls while hold is high
// Notes: queue state is read back over AXI4-Lite after each phase
`timescale 1ns/10ps
module tb_operand_queue_with_release;
    logic         ref_clk_in = 0;
    logic         rst_in     = 1;
    logic [4:0]   m          = 0;
    logic [4:0]   inc        = 0;
    logic [3:0]   sel        = 0;
    logic [63:0]  a          = 0;
    logic [63:0]  b          = 0;
    logic         hold       = 1;
    logic         stall, ready, taken;
    logic [127:0] opnd;
    logic [3:0]   c1, c2, c3;
    logic [11:0]  awaddr = 0, araddr = 0;
    logic [31:0]  wdata  = 0, rdata, rd_v;
    logic         awvalid = 0, wvalid = 0, bready = 0;
    logic         arvalid = 0, rready = 0;
    logic         awready, wready, bvalid, arready, rvalid;
    logic [1:0]   bresp, rresp, rs_v;
    int           error_cnt = 0, samples_checked = 0, cyc = 0;

    always #12.5 ref_clk_in = ~ref_clk_in;

    operand_queue_with_release uut (
        .ref_clk_in(ref_clk_in), .rst_in(rst_in),
        .load_first_operand_in(m[4]), .load_second_operand_in(m[3]),
        .load_shared_control_bits_in(m[2]), .release_everything_in(m[1]),
        .increment_in(inc), .offset_select_in(sel), .quad_select_in(m[0]),
        .first_operand_data_in(a), .second_operand_data_in(b),
        .quad_data_in({~b, ~a}), .first_control_in(a[3:0]),
        .second_control_in(b[3:0]), .shared_control_in(a[7:4]),
        .load_stall_out(stall), .operands_ready_out(ready),
        .operands_taken_in(taken), .output_operand_out(opnd),
        .first_control_out(c1), .second_control_out(c2),
        .shared_control_out(c3),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));

    exec_unit_model ex (
        .ref_clk_in(ref_clk_in), .hold_in(hold), .ready_in(ready),
        .data_in(opnd), .ctl_in({c3, c2, c1}), .taken_out(taken));

    task automatic chk(input string n, input logic [127:0] e,
                       input logic [127:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic chk_resp(input string n, input logic [1:0] e,
                            input logic [1:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask : chk_resp

    task automatic axi_wr(input logic [11:0] ad, input logic [31:0] d,
                          output logic [1:0] r);
        logic aw_ok, w_ok;
        aw_ok = 0;
        w_ok  = 0;
        @(posedge ref_clk_in);
        awaddr  <= ad;
        wdata   <= d;
        awvalid <= 1;
        wvalid  <= 1;
        bready  <= 1;
        while (!(aw_ok && w_ok)) begin
            @(posedge ref_clk_in);
            if (!aw_ok && awready === 1'b1) begin
                aw_ok = 1;
                awvalid <= 0;
            end
            if (!w_ok && wready === 1'b1) begin
                w_ok = 1;
                wvalid <= 0;
            end
        end
        do @(posedge ref_clk_in); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 0;
    endtask : axi_wr

    task automatic axi_rd(input logic [11:0] ad, output logic [31:0] d,
                          output logic [1:0] r);
        @(posedge ref_clk_in);
        araddr  <= ad;
        arvalid <= 1;
        rready  <= 1;
        do @(posedge ref_clk_in); while (arready !== 1'b1);
        arvalid <= 0;
        do @(posedge ref_clk_in); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 0;
    endtask : axi_rd

    // status word: full, write address, read address, released, used
    task automatic chk_st(input int u, r, rp, wp, f);
        axi_rd(opq_pkg::STATUS_OFFSET, rd_v, rs_v);
        chk("status", {f[0], 3'h0, wp[3:0], 4'h0, rp[3:0], 3'h0, r[4:0],
                       3'h0, u[4:0]}, rd_v);
    endtask : chk_st

    // mode bits: first, second, shared, release, quad
    task automatic ld(input logic [4:0] md, input logic [4:0] n,
                      input logic [3:0] s, input logic [63:0] x, y);
        @(posedge ref_clk_in);
        m   <= md;
        inc <= n;
        sel <= s;
        a   <= x;
        b   <= y;
    endtask : ld

    task automatic idle();
        @(posedge ref_clk_in);
        m <= 0;
    endtask : idle

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : tally_and_finish

    always @(posedge ref_clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            error_cnt++;
            tally_and_finish();
        end
    end

    initial begin
        repeat (6) @(posedge ref_clk_in);
        rst_in <= 0;
        ld(5'b11000, 1, 0, 64'ha0, 64'hb0);
        idle();
        repeat (3) @(posedge ref_clk_in);
        #1 chk("ready", 0, ready);
        chk_st(1, 0, 0, 1, 0);
        $display("test deferred done");
        ld(5'b00010, 0, 0, 0, 0);
        idle();
        repeat (2) @(posedge ref_clk_in);
        #1 chk("ready", 1, ready);
        chk("operand", {64'hb0, 64'ha0}, opnd);
        chk_st(0, 0, 1, 1, 1);
        $display("test release done");
        for (int k = 1; k < 4; k++) begin
            ld(k == 3 ? 5'b11010 : 5'b11000, 1, 0, 64'ha0 + k, 64'hb0 + k);
        end
        idle();
        chk_st(3, 3, 1, 4, 1);
        @(posedge ref_clk_in) hold <= 0;
        repeat (4) @(posedge ref_clk_in);
        #1 chk("taken count", 4, ex.got);
        for (int k = 0; k < 4; k++) begin
            chk("delivered", {64'hb0 + k, 64'ha0 + k}, ex.seen[k]);
        end
        chk_st(0, 0, 4, 4, 0);
        $display("test fifo done");
        @(posedge ref_clk_in) hold <= 1;
        ld(5'b11000, 16, 0, 64'hf, 64'hf);
        ld(5'b11010, 1, 0, 64'he, 64'he);
        #1 chk("stall", 1, stall);
        chk_st(16, 0, 4, 4, 0);
        ld(5'b00010, 0, 0, 0, 0);
        idle();
        @(posedge ref_clk_in) hold <= 0;
        repeat (20) @(posedge ref_clk_in);
        #1 chk("taken count", 20, ex.got);
        chk_st(0, 0, 4, 4, 0);
        $display("test overflow done");
        axi_wr(12'h048, 32'h1111_0000, rs_v);
        chk_resp("bresp", opq_pkg::RESP_OKAY, rs_v);
        axi_wr(12'h04c, 32'h0000_0001, rs_v);
        chk_resp("bresp", opq_pkg::RESP_OKAY, rs_v);
        axi_rd(12'h048, rd_v, rs_v);
        chk("offset", 32'h1111_0000, rd_v);
        axi_rd(12'h100, rd_v, rs_v);
        chk_resp("rresp", opq_pkg::RESP_SLVERR, rs_v);
        chk("unmapped data", 0, rd_v);
        axi_wr(12'h100, 32'h0000_0005, rs_v);
        chk_resp("bresp", opq_pkg::RESP_SLVERR, rs_v);
        @(posedge ref_clk_in) hold <= 1;
        // byte address 0x048 decodes to offset entry 9
        ld(5'b11100, 1, 9, 64'h1111, 64'h2222);
        ld(5'b10000, 1, 0, 64'h3333, 64'h0);
        ld(5'b10011, 1, 0, 64'h4444, 64'h5555);
        idle();
        repeat (2) @(posedge ref_clk_in);
        #1 chk("operand", {64'hf, 64'h1111}, opnd);
        @(posedge ref_clk_in) hold <= 0;
        repeat (5) @(posedge ref_clk_in);
        #1 chk("lane offsets", {64'h2222, 64'h3333}, ex.seen[21]);
        chk("control", {4'h1, 4'h2, 4'h3}, ex.seen_c[21]);
        chk("quad", {~64'h5555, ~64'h4444}, ex.seen[22]);
        chk_st(0, 0, 7, 7, 0);
        $display("test offsets done");
        tally_and_finish();
    end
endmodule : tb_operand_queue_with_release
